/* shared/bdme_map.svh */
`ifndef BDME_MAP_SVH
`define BDME_MAP_SVH

// ****************************************
// Register file positions
// ****************************************
`define BDME_REG_R0       5'h00
`define BDME_REG_R1       5'h01
`define BDME_PTR_X_LO     5'h1a
`define BDME_PTR_Y_LO     5'h1c
`define BDME_PTR_Z_LO     5'h1e

// ****************************************
// Reset values
// ****************************************
`define BDME_PC_RESET     16'h0000
`define BDME_SP_RESET     16'hffff

// ****************************************
// Cycle counts and steps
// ****************************************
`define BDME_CYC_ONE      2'h1
`define BDME_CYC_MEM      2'h2
`define BDME_CYC_CODE     2'h3
`define BDME_PC_STEP      16'h0001
`define BDME_PC_STEP_WIDE 16'h0002
`define BDME_ADDR_ONE     16'h0001

`endif

/* shared/bdme_pkg.sv */
package bdme_pkg;

  // ****************************************
  // Commands from the decoder
  // ****************************************
  typedef enum logic [4:0] {
    CMD_BRANCH_ON_HOLDING_CLEAR,
    CMD_BRANCH_ON_WRAP_SET,
    CMD_BRANCH_ON_WRAP_CLEAR,
    CMD_BRANCH_ON_GLOBAL_ENABLE_SET,
    CMD_BRANCH_ON_GLOBAL_ENABLE_CLEAR,
    CMD_MOVE,
    CMD_PAIR_COPY,
    CMD_CONSTANT_FILL,
    CMD_INDIRECT_FETCH,
    CMD_OFFSET_FETCH,
    CMD_ABSOLUTE_FETCH,
    CMD_INDIRECT_WRITE,
    CMD_OFFSET_WRITE,
    CMD_ABSOLUTE_WRITE,
    CMD_CODE_MEMORY_READ,
    CMD_CODE_MEMORY_READ_R0,
    CMD_CODE_MEMORY_WRITE,
    CMD_PORT_IN,
    CMD_PORT_OUT,
    CMD_PUSH,
    CMD_POP
  } bdme_cmd_t;

  typedef enum logic [1:0] {
    PTR_X,
    PTR_Y,
    PTR_Z
  } bdme_ptr_t;

  typedef enum logic [1:0] {
    AM_PLAIN,
    AM_POST_INC,
    AM_PRE_DEC
  } bdme_amode_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_CODE_WRITE
  } bdme_state_t;

endpackage : bdme_pkg

/* hw/bdme_exec.sv */
`timescale 1ns/1ps
`include "bdme_map.svh"
// What this block does
// - Holding flag clear: jump to PC+k+1
// - Wrap flag set/clear branches jump PC+k+1
// - Global enable set/clear branches jump PC+k+1
// - Post-increment fetch: read, then pointer plus one
// - Pre-decrement fetch: pointer minus one, then read
// - Offset fetch: pointer plus displacement, pointer kept
// - Absolute fetch from instruction address, two cycles
// - Post-increment write: store, then pointer plus one
// - Pre-decrement write: pointer minus one, then store
// - Offset write: pointer plus displacement, pointer kept
// - Absolute write to instruction address, two cycles
// - Code read: three cycles, third pointer, optional increment
// - Push source register in two cycles
// - Pop top byte into destination, two cycles
module bdme_exec (
  input  logic               mclk,
  input  logic               srst,
  input  logic               ce,
  input  logic               cmdValid,
  output logic               cmdReady,
  input  bdme_pkg::bdme_cmd_t   cmd,
  input  bdme_pkg::bdme_ptr_t   ptrSel,
  input  bdme_pkg::bdme_amode_t addrMode,
  input  logic [4:0]         dstReg,
  input  logic [4:0]         srcReg,
  input  logic [7:0]         constVal,
  input  logic [5:0]         disp,
  input  logic [15:0]        absAddr,
  input  logic [6:0]         branchOffset,
  input  logic [5:0]         portAddr,
  input  logic               holdingFlag,
  input  logic               wrapFlag,
  input  logic               globalEnable,
  output logic               retire,
  output logic [15:0]        pc,
  output logic [15:0]        sp,
  output logic [15:0]        dmAddr,
  output logic [7:0]         dmWrData,
  output logic               dmWrEn,
  output logic               dmRdEn,
  input  logic [7:0]         dmRdData,
  output logic [15:0]        pmAddr,
  output logic               pmRdEn,
  input  logic [7:0]         pmRdData,
  output logic               codeWrReq,
  output logic [15:0]        codeWrAddr,
  output logic [15:0]        codeWrData,
  input  logic               codeWrDone,
  output logic [5:0]         ioAddr,
  output logic               ioRdEn,
  input  logic [7:0]         ioRdData,
  output logic               ioWrEn,
  output logic [7:0]         ioWrData,
  input  logic [4:0]         regRdAddr,
  output logic [7:0]         regRdData
);
  import bdme_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  regsQ [0:31];
  bdme_state_t stateQ;
  logic [1:0]  cycQ;
  logic [1:0]  needQ;
  logic [4:0]  dstQ;
  logic        loadDmQ;
  logic        loadPmQ;
  logic [15:0] pcNextQ;
  logic [15:0] pcQ;
  logic [15:0] spQ;
  logic [15:0] dmAddrQ;
  logic [7:0]  dmWrDataQ;
  logic        dmWrEnQ;
  logic        dmRdEnQ;
  logic [15:0] pmAddrQ;
  logic        pmRdEnQ;
  logic [15:0] codeWrAddrQ;
  logic [15:0] codeWrDataQ;
  logic [5:0]  ioAddrQ;
  logic        ioWrEnQ;
  logic [7:0]  ioWrDataQ;
  logic [7:0]  regRdDataQ;

  // ****************************************
  // Decode of the offered command
  // ****************************************
  logic [4:0]  ptrLo;
  logic [4:0]  ptrHi;
  logic [15:0] ptrVal;
  logic [15:0] zVal;
  logic [15:0] effAddr;
  logic        taken;
  logic [1:0]  need;
  logic        isBranch;
  logic        isWide;
  logic        take;
  logic        lastCyc;
  logic [4:0]  pairDst;
  logic [4:0]  pairSrc;

  always_comb
  begin
    unique case (ptrSel)
      PTR_X:   ptrLo = `BDME_PTR_X_LO;
      PTR_Y:   ptrLo = `BDME_PTR_Y_LO;
      default: ptrLo = `BDME_PTR_Z_LO;
    endcase
  end

  assign ptrHi   = ptrLo | `BDME_REG_R1;
  assign ptrVal  = {regsQ[ptrHi], regsQ[ptrLo]};
  assign zVal    = {regsQ[`BDME_PTR_Z_LO | `BDME_REG_R1], regsQ[`BDME_PTR_Z_LO]};
  assign pairDst = {dstReg[4:1], 1'b0};
  assign pairSrc = {srcReg[4:1], 1'b0};

  always_comb
  begin
    effAddr = ptrVal;
    unique case (cmd)
      CMD_INDIRECT_FETCH, CMD_INDIRECT_WRITE:
        effAddr = (addrMode == AM_PRE_DEC) ? ptrVal - `BDME_ADDR_ONE : ptrVal;
      CMD_OFFSET_FETCH, CMD_OFFSET_WRITE:
        effAddr = ptrVal + {10'h000, disp};
      CMD_ABSOLUTE_FETCH, CMD_ABSOLUTE_WRITE:
        effAddr = absAddr;
      CMD_POP:
        effAddr = spQ + `BDME_ADDR_ONE;
      CMD_PUSH:
        effAddr = spQ;
      default:
        effAddr = ptrVal;
    endcase
  end

  always_comb
  begin
    taken    = 1'b0;
    isBranch = 1'b0;
    unique case (cmd)
      CMD_BRANCH_ON_HOLDING_CLEAR:       taken = ~holdingFlag;
      CMD_BRANCH_ON_WRAP_SET:            taken = wrapFlag;
      CMD_BRANCH_ON_WRAP_CLEAR:          taken = ~wrapFlag;
      CMD_BRANCH_ON_GLOBAL_ENABLE_SET:   taken = globalEnable;
      CMD_BRANCH_ON_GLOBAL_ENABLE_CLEAR: taken = ~globalEnable;
      default:                           taken = 1'b0;
    endcase
    isBranch = (cmd <= CMD_BRANCH_ON_GLOBAL_ENABLE_CLEAR);
  end

  always_comb
  begin
    unique case (cmd)
      CMD_INDIRECT_FETCH, CMD_OFFSET_FETCH, CMD_ABSOLUTE_FETCH, CMD_INDIRECT_WRITE, CMD_OFFSET_WRITE,
      CMD_ABSOLUTE_WRITE, CMD_PUSH, CMD_POP:
        need = `BDME_CYC_MEM;
      CMD_CODE_MEMORY_READ, CMD_CODE_MEMORY_READ_R0:
        need = `BDME_CYC_CODE;
      default:
        need = (isBranch && taken) ? `BDME_CYC_MEM : `BDME_CYC_ONE;
    endcase
  end

  assign isWide   = (cmd == CMD_ABSOLUTE_FETCH) || (cmd == CMD_ABSOLUTE_WRITE);
  assign take     = ce && cmdValid && (stateQ == ST_IDLE);
  assign lastCyc  = (stateQ == ST_BUSY) && (cycQ == needQ - `BDME_CYC_ONE);
  assign cmdReady = (stateQ == ST_IDLE);
  assign retire   = ce && ((take && need == `BDME_CYC_ONE && cmd != CMD_CODE_MEMORY_WRITE) || lastCyc ||
                    ((stateQ == ST_CODE_WRITE) && codeWrDone));

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      stateQ  <= ST_IDLE;
      cycQ    <= 2'h0;
      needQ   <= `BDME_CYC_ONE;
      dstQ    <= 5'h00;
      loadDmQ <= 1'b0;
      loadPmQ <= 1'b0;
      pcNextQ <= `BDME_PC_RESET;
    end
    else if (ce)
    begin
      if (take)
      begin
        cycQ    <= `BDME_CYC_ONE;
        needQ   <= need;
        dstQ    <= (cmd == CMD_CODE_MEMORY_READ_R0) ? `BDME_REG_R0 : dstReg;
        loadDmQ <= (cmd == CMD_INDIRECT_FETCH) || (cmd == CMD_OFFSET_FETCH) ||
                   (cmd == CMD_ABSOLUTE_FETCH) || (cmd == CMD_POP);
        loadPmQ <= (cmd == CMD_CODE_MEMORY_READ) || (cmd == CMD_CODE_MEMORY_READ_R0);
        pcNextQ <= taken ? pcQ + {{9{branchOffset[6]}}, branchOffset} + `BDME_PC_STEP
                 : pcQ + (isWide ? `BDME_PC_STEP_WIDE : `BDME_PC_STEP);
        if (cmd == CMD_CODE_MEMORY_WRITE)
          stateQ <= ST_CODE_WRITE;
        else if (need != `BDME_CYC_ONE)
          stateQ <= ST_BUSY;
      end
      else if (lastCyc || ((stateQ == ST_CODE_WRITE) && codeWrDone))
        stateQ <= ST_IDLE;
      else if (stateQ == ST_BUSY)
        cycQ <= cycQ + `BDME_CYC_ONE;
    end
  end

  // ****************************************
  // Program counter and stack pointer
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
      pcQ <= `BDME_PC_RESET;
    else if (ce && take && need == `BDME_CYC_ONE && cmd != CMD_CODE_MEMORY_WRITE)
      pcQ <= pcQ + (isWide ? `BDME_PC_STEP_WIDE : `BDME_PC_STEP);
    else if (ce && retire)
      pcQ <= pcNextQ;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      spQ <= `BDME_SP_RESET;
    else if (ce && take && cmd == CMD_PUSH)
      spQ <= spQ - `BDME_ADDR_ONE;
    else if (ce && take && cmd == CMD_POP)
      spQ <= spQ + `BDME_ADDR_ONE;
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 32; i++)
        regsQ[i] <= 8'h00;
    end
    else if (ce)
    begin
      if (take)
      begin
        unique case (cmd)
          CMD_MOVE:
            regsQ[dstReg] <= regsQ[srcReg];
          CMD_PAIR_COPY:
          begin
            regsQ[pairDst]             <= regsQ[pairSrc];
            regsQ[pairDst | `BDME_REG_R1] <= regsQ[pairSrc | `BDME_REG_R1];
          end
          CMD_CONSTANT_FILL:
            regsQ[dstReg] <= constVal;
          CMD_PORT_IN:
            regsQ[dstReg] <= ioRdData;
          CMD_INDIRECT_FETCH, CMD_INDIRECT_WRITE:
            if (addrMode == AM_POST_INC)
              {regsQ[ptrHi], regsQ[ptrLo]} <= ptrVal + `BDME_ADDR_ONE;
            else if (addrMode == AM_PRE_DEC)
              {regsQ[ptrHi], regsQ[ptrLo]} <= effAddr;
          CMD_CODE_MEMORY_READ:
            if (addrMode == AM_POST_INC)
              {regsQ[`BDME_PTR_Z_LO | `BDME_REG_R1], regsQ[`BDME_PTR_Z_LO]} <= zVal + `BDME_ADDR_ONE;
          default:
          begin
          end
        endcase
      end
      if (lastCyc && loadDmQ)
        regsQ[dstQ] <= dmRdData;
      if (lastCyc && loadPmQ)
        regsQ[dstQ] <= pmRdData;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      regRdDataQ <= 8'h00;
    else if (ce)
      regRdDataQ <= regsQ[regRdAddr];
  end

  // ****************************************
  // Memory and port strobes
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      dmAddrQ   <= 16'h0000;
      dmWrDataQ <= 8'h00;
      dmWrEnQ   <= 1'b0;
      dmRdEnQ   <= 1'b0;
      pmAddrQ   <= 16'h0000;
      pmRdEnQ   <= 1'b0;
      ioAddrQ   <= 6'h00;
      ioWrEnQ   <= 1'b0;
      ioWrDataQ <= 8'h00;
    end
    else if (ce)
    begin
      dmWrEnQ <= take && ((cmd == CMD_INDIRECT_WRITE) || (cmd == CMD_OFFSET_WRITE) ||
                 (cmd == CMD_ABSOLUTE_WRITE) || (cmd == CMD_PUSH));
      dmRdEnQ <= take && ((cmd == CMD_INDIRECT_FETCH) || (cmd == CMD_OFFSET_FETCH) ||
                 (cmd == CMD_ABSOLUTE_FETCH) || (cmd == CMD_POP));
      pmRdEnQ <= take && ((cmd == CMD_CODE_MEMORY_READ) || (cmd == CMD_CODE_MEMORY_READ_R0));
      ioWrEnQ <= take && (cmd == CMD_PORT_OUT);
      if (take)
      begin
        dmAddrQ   <= effAddr;
        dmWrDataQ <= regsQ[srcReg];
        pmAddrQ   <= zVal;
        ioAddrQ   <= portAddr;
        ioWrDataQ <= regsQ[srcReg];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      codeWrAddrQ <= 16'h0000;
      codeWrDataQ <= 16'h0000;
    end
    else if (ce && take && cmd == CMD_CODE_MEMORY_WRITE)
    begin
      codeWrAddrQ <= zVal;
      codeWrDataQ <= {regsQ[`BDME_REG_R1], regsQ[`BDME_REG_R0]};
    end
  end

  assign pc         = pcQ;
  assign sp         = spQ;
  assign dmAddr     = dmAddrQ;
  assign dmWrData   = dmWrDataQ;
  assign dmWrEn     = dmWrEnQ;
  assign dmRdEn     = dmRdEnQ;
  assign pmAddr     = pmAddrQ;
  assign pmRdEn     = pmRdEnQ;
  assign codeWrReq  = (stateQ == ST_CODE_WRITE);
  assign codeWrAddr = codeWrAddrQ;
  assign codeWrData = codeWrDataQ;
  assign ioAddr     = take ? portAddr : ioAddrQ;
  assign ioRdEn     = take && (cmd == CMD_PORT_IN);
  assign ioWrEn     = ioWrEnQ;
  assign ioWrData   = ioWrDataQ;
  assign regRdData  = regRdDataQ;

endmodule : bdme_exec

/* test/bdme_monitor.sv */
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module bdme_monitor (
  input logic                mclk,
  input logic                srst,
  input logic                ce,
  input logic                cmdValid,
  input logic                cmdReady,
  input bdme_pkg::bdme_cmd_t cmd,
  input logic [6:0]          branchOffset,
  input logic                holdingFlag,
  input logic                wrapFlag,
  input logic                globalEnable,
  input logic [15:0]         absAddr,
  input logic                retire,
  input logic [15:0]         pc,
  input logic [15:0]         sp,
  input logic [15:0]         dmAddr,
  input logic                dmWrEn,
  input logic                dmRdEn,
  input logic                pmRdEn,
  input logic                codeWrReq,
  input logic                codeWrDone
);
  import bdme_pkg::*;
  logic        tk;
  logic [15:0] pcQ;
  logic [6:0]  offQ;
  assign tk = ce && cmdValid && cmdReady;
  always_ff @(posedge mclk)
  begin
    if (tk)
    begin
      pcQ <= pc;
      offQ <= branchOffset;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_hold_untaken: assert property (tk && cmd == CMD_BRANCH_ON_HOLDING_CLEAR && holdingFlag |-> retire ##1 pc == pcQ + 16'h1)
    else $error("untaken branch wrong");
  a_wrap_taken: assert property (tk && (cmd == CMD_BRANCH_ON_WRAP_SET && wrapFlag || cmd == CMD_BRANCH_ON_WRAP_CLEAR && !wrapFlag)
    |-> !retire ##1 retire ##1 pc == pcQ + {{9{offQ[6]}}, offQ} + 16'h1) else $error("taken branch wrong");
  a_enable_taken: assert property (tk && (cmd == CMD_BRANCH_ON_GLOBAL_ENABLE_SET && globalEnable
    || cmd == CMD_BRANCH_ON_GLOBAL_ENABLE_CLEAR && !globalEnable) |-> !retire ##1 retire) else $error("enable branch wrong");
  a_fetch_strobe: assert property (tk && cmd inside {CMD_INDIRECT_FETCH, CMD_OFFSET_FETCH, CMD_ABSOLUTE_FETCH, CMD_POP}
    |=> dmRdEn && retire && !dmWrEn) else $error("fetch timing wrong");
  a_write_strobe: assert property (tk && cmd inside {CMD_INDIRECT_WRITE, CMD_OFFSET_WRITE, CMD_ABSOLUTE_WRITE, CMD_PUSH}
    |=> dmWrEn && retire && !dmRdEn) else $error("write timing wrong");
  a_abs_addr: assert property (tk && cmd inside {CMD_ABSOLUTE_FETCH, CMD_ABSOLUTE_WRITE} |=> dmAddr == $past(absAddr))
    else $error("absolute address wrong");
  a_code_read: assert property (tk && cmd inside {CMD_CODE_MEMORY_READ, CMD_CODE_MEMORY_READ_R0}
    |=> pmRdEn && !retire ##1 retire) else $error("code read timing wrong");
  a_push_sp: assert property (tk && cmd == CMD_PUSH |=> dmAddr == $past(sp) && sp == $past(sp) - 16'h1)
    else $error("push address wrong");
  a_single_cycle: assert property (tk && cmd inside {CMD_MOVE, CMD_PAIR_COPY, CMD_CONSTANT_FILL, CMD_PORT_IN, CMD_PORT_OUT}
    |-> retire) else $error("single cycle command late");
  a_code_hold: assert property (codeWrReq && !codeWrDone |=> codeWrReq)
    else $error("code write request dropped");
  c_push: cover property (tk && cmd == CMD_PUSH);
  c_code_done: cover property (codeWrReq && codeWrDone);
  c_stalled: cover property (!ce && cmdValid);
endmodule : bdme_monitor

bind bdme_exec bdme_monitor i_mon (.mclk(mclk), .srst(srst), .ce(ce), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .cmd(cmd), .branchOffset(branchOffset), .holdingFlag(holdingFlag), .wrapFlag(wrapFlag), .globalEnable(globalEnable),
  .absAddr(absAddr), .retire(retire), .pc(pc), .sp(sp), .dmAddr(dmAddr), .dmWrEn(dmWrEn), .dmRdEn(dmRdEn),
  .pmRdEn(pmRdEn), .codeWrReq(codeWrReq), .codeWrDone(codeWrDone));

/* test/bdme_mem_model.sv */
`timescale 1ns/1ps
// ****************
// Memories and ports
// ****************
module bdme_mem_model #(
  parameter int WAIT = 3
) (
  input  logic        mclk,
  input  logic [15:0] dmAddr,
  input  logic [7:0]  dmWrData,
  input  logic        dmWrEn,
  input  logic        dmRdEn,
  output logic [7:0]  dmRdData,
  input  logic [15:0] pmAddr,
  input  logic        pmRdEn,
  output logic [7:0]  pmRdData,
  input  logic        codeWrReq,
  output logic        codeWrDone,
  input  logic [5:0]  ioAddr,
  input  logic        ioRdEn,
  output logic [7:0]  ioRdData
);
  logic [7:0] mem [0:255];
  logic [7:0] junk = 8'ha5;
  int         cnt = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3c;
  // Unselected lines show a moving pattern
  always @(posedge mclk)
  begin
    if (dmWrEn) mem[dmAddr[7:0]] <= dmWrData;
    junk <= junk + 8'h35;
    pmRdData <= pmRdEn ? pmAddr[7:0] ^ 8'hc3 : junk;
    cnt <= (codeWrReq && !codeWrDone) ? cnt + 1 : 0;
  end
  assign dmRdData = dmRdEn ? mem[dmAddr[7:0]] : junk;
  assign ioRdData = ioRdEn ? {2'h0, ioAddr} ^ 8'h99 : ~junk;
  assign codeWrDone = codeWrReq && cnt == WAIT;
endmodule : bdme_mem_model

/* test/branch_and_data_move_exec_tb.sv */
`timescale 1ns/1ps
module branch_and_data_move_exec_tb;
  import bdme_pkg::*;
  logic        mclk = 1'b0, srst = 1'b1, ce = 1'b1, cmdValid = 1'b0, holdingFlag = 1'b0, wrapFlag = 1'b0;
  logic        globalEnable = 1'b0, cmdReady, retire, dmWrEn, dmRdEn, pmRdEn, codeWrReq, codeWrDone;
  logic        ioRdEn, ioWrEn, tb, pcChk = 1'b0;
  bdme_cmd_t   cmd = CMD_MOVE;
  bdme_ptr_t   ptrSel = PTR_X;
  bdme_amode_t addrMode = AM_PLAIN;
  logic [4:0]  dstReg = 5'h0, srcReg = 5'h0, regRdAddr = 5'h0;
  logic [5:0]  disp = 6'h0, portAddr = 6'h0, ioAddr;
  logic [6:0]  branchOffset = 7'h0;
  logic [7:0]  constVal = 8'h0, dmWrData, dmRdData, pmRdData, ioRdData, ioWrData, regRdData, v, p;
  logic [15:0] absAddr = 16'h0, pc, sp, dmAddr, pmAddr, codeWrAddr, codeWrData, pcM = 16'h0, pcE;
  logic [23:0] expQ[$], wrQ[$], e;
  logic [31:0] seed = 32'h7aec0017, r;
  int          miscompares = 0, n_checks = 0, cyc = 0, tk = 0;

  always #2 mclk = ~mclk;

  bdme_exec i_dut (.mclk(mclk), .srst(srst), .ce(ce), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
    .ptrSel(ptrSel), .addrMode(addrMode), .dstReg(dstReg), .srcReg(srcReg), .constVal(constVal), .disp(disp),
    .absAddr(absAddr), .branchOffset(branchOffset), .portAddr(portAddr), .holdingFlag(holdingFlag),
    .wrapFlag(wrapFlag), .globalEnable(globalEnable), .retire(retire), .pc(pc), .sp(sp), .dmAddr(dmAddr),
    .dmWrData(dmWrData), .dmWrEn(dmWrEn), .dmRdEn(dmRdEn), .dmRdData(dmRdData), .pmAddr(pmAddr), .pmRdEn(pmRdEn),
    .pmRdData(pmRdData), .codeWrReq(codeWrReq), .codeWrAddr(codeWrAddr), .codeWrData(codeWrData),
    .codeWrDone(codeWrDone), .ioAddr(ioAddr), .ioRdEn(ioRdEn), .ioRdData(ioRdData), .ioWrEn(ioWrEn),
    .ioWrData(ioWrData), .regRdAddr(regRdAddr), .regRdData(regRdData));
  bdme_mem_model i_mem (.mclk(mclk), .dmAddr(dmAddr), .dmWrData(dmWrData), .dmWrEn(dmWrEn), .dmRdEn(dmRdEn),
    .dmRdData(dmRdData), .pmAddr(pmAddr), .pmRdEn(pmRdEn), .pmRdData(pmRdData), .codeWrReq(codeWrReq),
    .codeWrDone(codeWrDone), .ioAddr(ioAddr), .ioRdEn(ioRdEn), .ioRdData(ioRdData));

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic go(input logic [7:0] lat, input logic [15:0] nxt);
    expQ.push_back({lat, nxt});
    cmdValid = 1'b1;
    do
      @(posedge mclk);
    while (!(cmdReady === 1'b1 && ce === 1'b1));
    #1;
    pcM = nxt;
  endtask : go

  task automatic put(input bdme_cmd_t c, input logic [4:0] d, input logic [4:0] s, input logic [7:0] lat,
    input logic [15:0] step);
    cmd = c;
    dstReg = d;
    srcReg = s;
    go(lat, pcM + step);
  endtask : put

  task automatic fill(input logic [4:0] d, input logic [7:0] k);
    constVal = k;
    put(CMD_CONSTANT_FILL, d, 5'h0, 8'h0, 16'h1);
  endtask : fill

  task automatic rd(input logic [4:0] a, input logic [7:0] x);
    cmdValid = 1'b0;
    regRdAddr = a;
    do
      @(posedge mclk);
    while (cmdReady !== 1'b1);
    @(posedge mclk);
    #1;
    chk(regRdData, x);
  endtask : rd

  // ****************
  // Watcher and stimulus
  // ****************
  always @(posedge mclk)
  begin
    cyc++;
    if (pcChk) chk(pc, pcE);
    pcChk = 1'b0;
    if (ce && cmdValid && cmdReady) tk = cyc;
    if (ce && retire)
    begin
      e = expQ.size() ? expQ.pop_front() : 24'hfe0000;
      if (e[23:16] != 8'hff) chk(cyc - tk, e[23:16]);
      pcE = e[15:0];
      pcChk = 1'b1;
    end
    if (dmWrEn) chk({dmAddr, dmWrData}, wrQ.size() ? wrQ.pop_front() : 24'h0);
    if (ioWrEn) chk({10'h3ff, ioAddr, ioWrData}, wrQ.size() ? wrQ.pop_front() : 24'h0);
    if (codeWrReq && codeWrDone) chk({codeWrAddr, codeWrData}, 32'h00420081);
    if (cyc > 3000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    #1;
    srst = 1'b0;
    chk(sp, 16'hffff);
    ce = 1'b0;
    cmdValid = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    ce = 1'b1;
    fill(5'h1a, 8'h10);
    fill(5'h1b, 8'h00);
    fill(5'h1c, 8'h20);
    fill(5'h1d, 8'h00);
    fill(5'h1e, 8'h40);
    fill(5'h1f, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      r = rnd();
      branchOffset = r[6:0];
      holdingFlag = i[0];
      wrapFlag = i[0];
      globalEnable = i[0];
      tb = ((i / 2) % 2 == 1) ? i[0] : !i[0];
      put(bdme_cmd_t'(i / 2), 5'h0, 5'h0, {7'h0, tb}, tb ? {{9{r[6]}}, r[6:0]} + 16'h1 : 16'h1);
    end
    addrMode = AM_POST_INC;
    put(CMD_INDIRECT_FETCH, 5'h2, 5'h0, 8'h1, 16'h1);
    addrMode = AM_PRE_DEC;
    put(CMD_INDIRECT_FETCH, 5'h3, 5'h0, 8'h1, 16'h1);
    ptrSel = PTR_Y;
    addrMode = AM_PLAIN;
    disp = r[12:7];
    put(CMD_OFFSET_FETCH, 5'h4, 5'h0, 8'h1, 16'h1);
    absAddr = {8'h0, r[20:13]};
    put(CMD_ABSOLUTE_FETCH, 5'h5, 5'h0, 8'h1, 16'h2);
    rd(5'h2, 8'h2c);
    rd(5'h3, 8'h2c);
    rd(5'h1a, 8'h10);
    rd(5'h4, (8'h20 + disp) ^ 8'h3c);
    rd(5'h1c, 8'h20);
    rd(5'h5, absAddr[7:0] ^ 8'h3c);
    v = r[31:24];
    fill(5'h6, v);
    ptrSel = PTR_Z;
    addrMode = AM_POST_INC;
    wrQ.push_back({16'h0040, v});
    put(CMD_INDIRECT_WRITE, 5'h0, 5'h6, 8'h1, 16'h1);
    ptrSel = PTR_X;
    addrMode = AM_PRE_DEC;
    wrQ.push_back({16'h000f, v});
    put(CMD_INDIRECT_WRITE, 5'h0, 5'h6, 8'h1, 16'h1);
    ptrSel = PTR_Z;
    addrMode = AM_PLAIN;
    wrQ.push_back({16'h0041 + disp, v});
    put(CMD_OFFSET_WRITE, 5'h0, 5'h6, 8'h1, 16'h1);
    absAddr = 16'h0080;
    wrQ.push_back({16'h0080, v});
    put(CMD_ABSOLUTE_WRITE, 5'h0, 5'h6, 8'h1, 16'h2);
    wrQ.push_back({16'hffff, v});
    put(CMD_PUSH, 5'h0, 5'h6, 8'h1, 16'h1);
    put(CMD_POP, 5'h7, 5'h0, 8'h1, 16'h1);
    r = rnd();
    p = r[7:0];
    portAddr = p[5:0];
    wrQ.push_back({10'h3ff, p[5:0], v});
    put(CMD_PORT_OUT, 5'h0, 5'h6, 8'h0, 16'h1);
    put(CMD_PORT_IN, 5'h8, 5'h0, 8'h0, 16'h1);
    put(CMD_MOVE, 5'h9, 5'h8, 8'h0, 16'h1);
    put(CMD_PAIR_COPY, 5'ha, 5'h6, 8'h0, 16'h1);
    addrMode = AM_POST_INC;
    put(CMD_CODE_MEMORY_READ, 5'hc, 5'h0, 8'h2, 16'h1);
    addrMode = AM_PLAIN;
    put(CMD_CODE_MEMORY_READ_R0, 5'h0, 5'h0, 8'h2, 16'h1);
    put(CMD_CODE_MEMORY_WRITE, 5'h0, 5'h0, 8'hff, 16'h1);
    rd(5'h7, v);
    rd(5'h8, {2'h0, p[5:0]} ^ 8'h99);
    rd(5'h9, {2'h0, p[5:0]} ^ 8'h99);
    rd(5'ha, v);
    rd(5'hb, v);
    rd(5'hc, 8'h82);
    rd(5'h0, 8'h81);
    rd(5'h1e, 8'h42);
    rd(5'h1a, 8'h0f);
    chk(sp, 16'hffff);
    finish_test();
  end
endmodule : branch_and_data_move_exec_tb
